// File: include/fdm_pkg.sv
// Constants and carrier types for the field device frame master
package fdm_pkg;
    // Timing: reply timeout in its own unit, then in clock cycles
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned RSP_TIMEOUT_MS  = 300;
    localparam int unsigned RSP_TIMEOUT_CYC = RSP_TIMEOUT_MS * (CLK_HZ / 1000);
    // Frame bytes and field positions
    localparam logic [7:0] PREAMBLE_BYTE   = 8'hff;
    localparam logic [7:0] DELIM_SHORT_REQ = 8'h02;
    localparam logic [7:0] PRIMARY_MASTER  = 8'h80;
    localparam int         LONG_BIT        = 7;
    localparam int         BURST_BIT       = 6;
    localparam int         ERR_BIT         = 7;
    localparam logic [7:0] CMD_IDENTIFY    = 8'h00;
    localparam logic [7:0] CMD_SET_ADDR    = 8'h06;
    localparam logic [2:0] LONG_ADDR_LEN   = 3'd5;
    localparam logic [2:0] SHORT_ADDR_LEN  = 3'd1;
    localparam logic [7:0] LONG_CMD_IDX    = 8'd6;
    localparam logic [7:0] SHORT_CMD_IDX   = 8'd2;
    localparam logic [7:0] MIN_REQ_LEN     = 8'd5;
    localparam logic [7:0] REQ_MAX_LEN     = 8'd239;
    // Autonomous frame: index of check byte without and with one data byte
    localparam logic [7:0] AUTO_CHK_IDX    = 8'd4;
    localparam logic [7:0] AUTO_CHK_IDX_D  = 8'd5;
    localparam logic [4:0] PRE_MIN         = 5'd5;
    localparam logic [4:0] PRE_MAX         = 5'd20;
    localparam logic [5:0] SCAN_FIRST      = 6'h01;
    localparam logic [5:0] SCAN_LAST       = 6'h3f;
    localparam int         CHAN_W          = 2;

    typedef struct packed {
        logic              valid;
        logic              last;
        logic [CHAN_W-1:0] chan;
        logic [7:0]        data;
    } cmd_beat_t;

    typedef struct packed {
        logic              valid;
        logic              last;
        logic              chk_err;
        logic              no_answer;
        logic [CHAN_W-1:0] chan;
        logic [7:0]        data;
    } rsp_beat_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_PRE  = 5'b00010,
        ST_SEND = 5'b00100,
        ST_WAIT = 5'b01000,
        ST_RECV = 5'b10000
    } eng_t;

    typedef enum logic [4:0] {
        RX_ADDR = 5'b00001,
        RX_CMD  = 5'b00010,
        RX_CNT  = 5'b00100,
        RX_PAY  = 5'b01000,
        RX_CHK  = 5'b10000
    } rx_t;
endpackage : fdm_pkg

// File: hw/field_device_frame_master.sv
// Four-channel frame master: polling, address scan, request/response relay
module field_device_frame_master #(
    parameter int unsigned TIMEOUT_CYC = fdm_pkg::RSP_TIMEOUT_CYC,
    parameter int          NUM_CHAN    = 4
) (
    input  wire logic                          REF_CLK,
    input  wire logic                          SRST,
    input  wire logic                          PROTO_EN,
    input  wire logic [4:0]                    PREAMBLE_LEN,
    input  wire fdm_pkg::cmd_beat_t            CMD,
    output logic                               CMD_READY,
    output fdm_pkg::rsp_beat_t                 RSP,
    output logic [fdm_pkg::CHAN_W-1:0]         LINK_CHAN,
    output logic                               TX_VALID,
    output logic [7:0]                         TX_DATA,
    input  wire logic                          TX_READY,
    input  wire logic                          RX_VALID,
    input  wire logic [7:0]                    RX_DATA,
    output logic [NUM_CHAN-1:0]                COMM_ERR
);
    import fdm_pkg::*;

    localparam logic [CHAN_W-1:0] LAST_CHAN = CHAN_W'(NUM_CHAN - 1);

    // Bytes of a poll frame; the data byte of command 6 is the new address 0
    function automatic logic [7:0] auto_byte(input logic [7:0] i,
                                             input logic [5:0] a,
                                             input logic [7:0] c);
        logic [7:0] b;
        b = 8'h00;
        unique case (i)
            8'd0:    b = DELIM_SHORT_REQ;
            8'd1:    b = PRIMARY_MASTER | {2'b00, a};
            8'd2:    b = c;
            8'd3:    b = (c == CMD_SET_ADDR) ? 8'd1 : 8'd0;
            default: b = 8'h00;
        endcase
        return b;
    endfunction : auto_byte

    function automatic logic [4:0] clamp_pre(input logic [4:0] n);
        return (n < PRE_MIN) ? PRE_MIN : (n > PRE_MAX) ? PRE_MAX : n;
    endfunction : clamp_pre

    ////////////////////////////////////////////////////////////////////////
    // Client request intake
    logic [7:0]        req_mem [0:255];
    logic [7:0]        wr_idx, next_wr_idx, req_len, next_len;
    logic [CHAN_W-1:0] req_chan, next_chan_req;
    logic              req_full, next_full, next_ready;
    logic              req_long, next_long, req_burst, next_burst;
    logic              req_cmd0, next_cmd0, req_over, next_over;
    logic              release_req;
    logic              take;

    assign take = CMD.valid && CMD_READY;

    // Flags gathered per byte so the whole frame is judged at its last beat
    always_comb begin
        next_wr_idx   = wr_idx;
        next_len      = req_len;
        next_chan_req = req_chan;
        next_full     = req_full;
        next_long     = req_long;
        next_burst    = req_burst;
        next_cmd0     = req_cmd0;
        next_over     = req_over;
        if (release_req)
            next_full = 1'b0;
        if (take) begin
            next_wr_idx = wr_idx + 8'd1;
            if (wr_idx == 8'd0) begin
                next_long     = CMD.data[LONG_BIT];
                next_chan_req = CMD.chan;
                next_burst    = 1'b0;
                next_cmd0     = 1'b0;
                next_over     = 1'b0;
            end
            if (wr_idx == 8'd1)
                next_burst = CMD.data[BURST_BIT];
            if (wr_idx == (req_long ? LONG_CMD_IDX : SHORT_CMD_IDX))
                next_cmd0 = (CMD.data == CMD_IDENTIFY);
            if (wr_idx >= REQ_MAX_LEN)
                next_over = 1'b1;
            if (CMD.last) begin
                next_wr_idx = 8'd0;
                next_len    = wr_idx + 8'd1;
                // Bad frames vanish with no answer, as burst ones must
                next_full   = !next_burst && (next_long || next_cmd0)
                              && !next_over && (wr_idx >= 8'd4);
            end
        end
        next_ready = !next_full;
    end

    always_ff @(posedge REF_CLK) begin
        if (take)
            req_mem[wr_idx] <= CMD.data;
        if (SRST) begin
            wr_idx    <= 8'd0;
            req_len   <= 8'd0;
            req_chan  <= '0;
            req_full  <= 1'b0;
            req_long  <= 1'b0;
            req_burst <= 1'b0;
            req_cmd0  <= 1'b0;
            req_over  <= 1'b0;
            CMD_READY <= 1'b0;
        end else begin
            wr_idx    <= next_wr_idx;
            req_len   <= next_len;
            req_chan  <= next_chan_req;
            req_full  <= next_full;
            req_long  <= next_long;
            req_burst <= next_burst;
            req_cmd0  <= next_cmd0;
            req_over  <= next_over;
            CMD_READY <= next_ready;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transaction engine: one channel on the modem at a time
    eng_t              state, next_state;
    rx_t               rx, next_rx;
    logic [CHAN_W-1:0] chan, next_chan;
    logic              cur_ext, next_ext;
    logic [7:0]        cur_cmd, next_cmd, idx, next_idx, end_idx, next_end;
    logic [5:0]        cur_addr, next_addr;
    logic [4:0]        pre_cnt, next_pre, pre_len;
    logic [7:0]        tx_chk, next_tx_chk, next_tx_data, nbyte;
    logic              next_tx_valid;
    logic [31:0]       timer, next_timer;
    logic [2:0]        addr_left, next_addr_left;
    logic [7:0]        rx_left, next_rx_left, rx_chk, next_rx_chk;
    logic              rx_stat, next_rx_stat, first, next_first;
    logic [NUM_CHAN-1:0] scan, next_scan, fix, next_fix;
    logic [NUM_CHAN-1:0] turn_ext, next_turn, stat_err, next_stat_err;
    logic [5:0]        scan_addr [NUM_CHAN], next_scan_addr [NUM_CHAN];
    rsp_beat_t         next_rsp;
    logic              fin, good;

    assign pre_len = clamp_pre(PREAMBLE_LEN);
    assign nbyte   = cur_ext ? req_mem[idx] : auto_byte(idx, cur_addr, cur_cmd);

    always_comb begin
        next_state = state;       next_rx = rx;         next_chan = chan;
        next_ext = cur_ext;       next_cmd = cur_cmd;   next_addr = cur_addr;
        next_idx = idx;           next_end = end_idx;   next_pre = pre_cnt;
        next_tx_chk = tx_chk;     next_tx_data = TX_DATA;
        next_tx_valid = TX_VALID; next_timer = timer;
        next_addr_left = addr_left; next_rx_left = rx_left;
        next_rx_chk = rx_chk;     next_rx_stat = rx_stat; next_first = first;
        next_scan = scan;         next_fix = fix;       next_turn = turn_ext;
        next_stat_err = stat_err; next_scan_addr = scan_addr;
        next_rsp = '0;
        next_rsp.chan = chan;
        release_req = 1'b0;
        fin = 1'b0;
        good = 1'b0;
        unique case (state)
            ST_IDLE: if (PROTO_EN) begin
                // Client frame only on its turn; never to a scanning channel
                next_ext = req_full && req_chan == chan && turn_ext[chan]
                           && !scan[chan];
                next_turn[chan] = !next_ext;
                next_cmd  = fix[chan] ? CMD_SET_ADDR : CMD_IDENTIFY;
                next_addr = scan[chan] ? scan_addr[chan] : 6'h00;
                next_end  = next_ext ? req_len - 8'd1 :
                            fix[chan] ? AUTO_CHK_IDX_D : AUTO_CHK_IDX;
                next_idx = 8'd0;
                next_pre = 5'd1;
                next_tx_valid = 1'b1;
                next_tx_data  = PREAMBLE_BYTE;
                next_state = ST_PRE;
            end
            ST_PRE: if (TX_READY) begin
                if (pre_cnt < pre_len) begin
                    next_pre = pre_cnt + 5'd1;
                end else begin
                    next_tx_data = nbyte;
                    next_tx_chk  = nbyte;
                    next_idx     = 8'd1;
                    next_state   = ST_SEND;
                end
            end
            ST_SEND: if (TX_READY) begin
                // Bytes go to the tone modem of the selected loop
                if (idx < end_idx) begin
                    next_tx_data = nbyte;
                    next_tx_chk  = tx_chk ^ nbyte;
                    next_idx     = idx + 8'd1;
                end else if (idx == end_idx) begin
                    next_tx_data = tx_chk;
                    next_idx     = idx + 8'd1;
                end else begin
                    next_tx_valid = 1'b0;
                    next_timer    = 32'd0;
                    next_state    = ST_WAIT;
                end
            end
            ST_WAIT, ST_RECV: begin
                next_timer = timer + 32'd1;
                if (RX_VALID && (state == ST_RECV ||
                                 RX_DATA != PREAMBLE_BYTE)) begin
                    next_rsp.valid = cur_ext;
                    next_rsp.data  = RX_DATA;
                    next_rx_chk    = rx_chk ^ RX_DATA;
                    if (state == ST_WAIT) begin
                        next_rx_chk = RX_DATA;
                        next_addr_left = RX_DATA[LONG_BIT] ?
                                         LONG_ADDR_LEN : SHORT_ADDR_LEN;
                        next_rx    = RX_ADDR;
                        next_state = ST_RECV;
                    end else begin
                        unique case (rx)
                            RX_ADDR: begin
                                next_addr_left = addr_left - 3'd1;
                                if (addr_left == 3'd1)
                                    next_rx = RX_CMD;
                            end
                            RX_CMD: next_rx = RX_CNT;
                            RX_CNT: begin
                                next_rx_left = RX_DATA;
                                next_first   = 1'b1;
                                next_rx_stat = 1'b0;
                                next_rx = (RX_DATA == 8'd0) ? RX_CHK : RX_PAY;
                            end
                            RX_PAY: begin
                                if (first)
                                    next_rx_stat = RX_DATA[ERR_BIT];
                                next_first   = 1'b0;
                                next_rx_left = rx_left - 8'd1;
                                if (rx_left == 8'd1)
                                    next_rx = RX_CHK;
                            end
                            RX_CHK: begin
                                fin  = 1'b1;
                                good = (rx_chk == RX_DATA);
                                next_rsp.last    = 1'b1;
                                next_rsp.chk_err = !good;
                            end
                        endcase
                    end
                end else if (timer >= TIMEOUT_CYC - 32'd1) begin
                    fin = 1'b1;
                    next_rsp.valid     = cur_ext;
                    next_rsp.last      = cur_ext;
                    next_rsp.no_answer = cur_ext;
                    next_rsp.data      = 8'h00;
                end
            end
        endcase
        if (fin) begin
            next_state = ST_IDLE;
            next_chan  = (chan == LAST_CHAN) ? '0 : chan + 1'b1;
            if (good)
                next_stat_err[chan] = rx_stat;
            if (cur_ext) begin
                release_req = 1'b1;
            end else if (fix[chan]) begin
                next_fix[chan] = 1'b0;
                if (good)
                    next_scan[chan] = 1'b0;
            end else if (scan[chan]) begin
                if (good && cur_addr == 6'h00)
                    next_scan[chan] = 1'b0;
                else if (good)
                    next_fix[chan] = 1'b1;
                else
                    next_scan_addr[chan] = (cur_addr == SCAN_LAST) ?
                                           6'h00 : cur_addr + 6'd1;
            end else if (!good) begin
                next_scan[chan] = 1'b1;
                next_scan_addr[chan] = SCAN_FIRST;
            end
        end
    end

    // State registers; outputs taken straight from them
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            state <= ST_IDLE;   rx <= RX_ADDR;   chan <= '0;
            cur_ext <= 1'b0;    cur_cmd <= 8'h00; cur_addr <= 6'h00;
            idx <= 8'd0;        end_idx <= 8'd0; pre_cnt <= 5'd0;
            tx_chk <= 8'h00;    timer <= 32'd0;  addr_left <= 3'd0;
            rx_left <= 8'd0;    rx_chk <= 8'h00; rx_stat <= 1'b0;
            first <= 1'b0;      scan <= '0;      fix <= '0;
            turn_ext <= '0;     stat_err <= '0;
            for (int i = 0; i < NUM_CHAN; i++)
                scan_addr[i] <= 6'h00;
            TX_VALID <= 1'b0;   TX_DATA <= 8'h00; LINK_CHAN <= '0;
            RSP <= '0;          COMM_ERR <= '0;
        end else begin
            state <= next_state; rx <= next_rx;   chan <= next_chan;
            cur_ext <= next_ext; cur_cmd <= next_cmd; cur_addr <= next_addr;
            idx <= next_idx;     end_idx <= next_end; pre_cnt <= next_pre;
            tx_chk <= next_tx_chk; timer <= next_timer;
            addr_left <= next_addr_left; rx_left <= next_rx_left;
            rx_chk <= next_rx_chk; rx_stat <= next_rx_stat;
            first <= next_first; scan <= next_scan; fix <= next_fix;
            turn_ext <= next_turn; stat_err <= next_stat_err;
            scan_addr <= next_scan_addr;
            TX_VALID <= next_tx_valid; TX_DATA <= next_tx_data;
            LINK_CHAN <= next_chan;
            RSP <= next_rsp;
            COMM_ERR <= next_scan | next_stat_err;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_bad_last(logic cond);
        take && CMD.last && cond;
    endsequence

    property p_preamble;
        @(posedge REF_CLK) disable iff (SRST)
        state == ST_PRE |-> TX_VALID && TX_DATA == PREAMBLE_BYTE;
    endproperty
    a_preamble: assert property (p_preamble)
        else $error("preamble byte not 0xff");

    property p_scan_err;
        @(posedge REF_CLK) disable iff (SRST)
        |scan |-> (COMM_ERR & scan) == scan;
    endproperty
    a_scan_err: assert property (p_scan_err)
        else $error("scan without error report");

    property p_one_chan;
        @(posedge REF_CLK) disable iff (SRST)
        state != ST_IDLE |=> state == ST_IDLE || $stable(LINK_CHAN);
    endproperty
    a_one_chan: assert property (p_one_chan)
        else $error("channel changed mid transaction");

    property p_burst_drop;
        @(posedge REF_CLK) disable iff (SRST)
        s_bad_last(wr_idx > 8'd1 && req_burst) |=> !req_full ##1 CMD_READY;
    endproperty
    a_burst_drop: assert property (p_burst_drop)
        else $error("burst request kept");

    property p_short_cmd;
        @(posedge REF_CLK) disable iff (SRST)
        s_bad_last(wr_idx > SHORT_CMD_IDX && !req_long && !req_cmd0)
        |=> !req_full;
    endproperty
    a_short_cmd: assert property (p_short_cmd)
        else $error("short address with nonzero command kept");

    property p_addr0;
        @(posedge REF_CLK) disable iff (SRST)
        state == ST_SEND && idx == 8'd2 && !cur_ext && !scan[chan]
        |-> TX_DATA == PRIMARY_MASTER;
    endproperty
    a_addr0: assert property (p_addr0)
        else $error("poll not at short address 0");

    property p_check;
        @(posedge REF_CLK) disable iff (SRST)
        state == ST_SEND && TX_READY && idx == end_idx
        |=> TX_VALID && TX_DATA == $past(tx_chk);
    endproperty
    a_check: assert property (p_check)
        else $error("check byte wrong");

    property p_fix;
        @(posedge REF_CLK) disable iff (SRST)
        fin && good && !cur_ext && scan[chan] && !fix[chan]
        && cur_addr != 6'h00 |=> fix[$past(chan)];
    endproperty
    a_fix: assert property (p_fix)
        else $error("found device not marked for readdress");

    // The readdress goes out on that channel's next turn, not at once
    property p_fix_cmd;
        @(posedge REF_CLK) disable iff (SRST)
        state == ST_PRE && fix[chan] |-> cur_cmd == CMD_SET_ADDR;
    endproperty
    a_fix_cmd: assert property (p_fix_cmd)
        else $error("readdress not sent with command 6");
endmodule : field_device_frame_master

// File: verification/loop_device_model.sv
// Behavioural loop device per channel: checks requests, answers them
module loop_device_model (
    input  wire logic       clk,
    input  wire logic [1:0] chan,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    input  wire logic [1:0] mode,
    input  wire logic [4:0] pre_len,
    output logic [5:0]      addr [4],
    output int              bad
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] q [$];
    logic [7:0] r [$];
    logic [7:0] x;
    int         pre;
    int         al;

    // Mode 1 mutes long frames, mode 2 spoils their check byte
    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        addr = '{6'h01, 6'h02, 6'h03, 6'h04};
        bad = 0;
        pre = 0;
        forever begin
            @(negedge clk) tx_ready = $urandom_range(2) != 0;
            @(posedge clk);
            if (tx_valid && tx_ready) begin
                if (q.size() == 0 && tx_data == 8'hff)
                    pre++;
                else
                    q.push_back(tx_data);
            end
            al = (q.size() > 0 && q[0][7]) ? 5 : 1;
            if (q.size() > al + 2 && q.size() == al + 4 + q[al + 2]) begin
                x = 8'h00;
                foreach (q[i]) x ^= q[i];
                if (pre != pre_len || x != 8'h00)
                    bad++;
                if (q[0][7] ? mode != 2'd1 : q[1][5:0] == addr[chan]) begin
                    if (!q[0][7] && q[2] == 8'h06)
                        addr[chan] = q[4][5:0];
                    r = {q[0] | 8'h04, q[1:al + 1], 8'h02, 8'h00, 8'h00};
                    x = 8'h00;
                    foreach (r[i]) x ^= r[i];
                    r.push_back((q[0][7] && mode == 2'd2) ? ~x : x);
                    r = {8'hff, 8'hff, r};
                    // Hold the modem busy so no request byte goes unseen
                    @(negedge clk) tx_ready = 1'b0;
                    repeat (3) @(negedge clk);
                    foreach (r[i]) begin
                        rx_valid = 1'b1;
                        rx_data = r[i];
                        @(negedge clk) rx_valid = 1'b0;
                        rx_data = ~r[i]; // No stale byte on an idle line
                        @(negedge clk);
                    end
                end
                q.delete();
                pre = 0;
            end
        end
    end
endmodule : loop_device_model

// File: verification/tb_field_device_frame_master.sv
// Bench for the frame master: scan, refusals and client relay
module tb_field_device_frame_master;
    timeunit 1ns;
    timeprecision 1ns;
    import fdm_pkg::*;
    logic        REF_CLK = 1'b0;
    logic        SRST = 1'b1;
    logic        PROTO_EN = 1'b0;
    logic [4:0]  PREAMBLE_LEN;
    cmd_beat_t   CMD;
    logic        CMD_READY, TX_VALID, TX_READY, RX_VALID;
    rsp_beat_t   RSP;
    logic [1:0]  LINK_CHAN, mode = 2'd0;
    logic [7:0]  TX_DATA, RX_DATA;
    logic [3:0]  COMM_ERR;
    logic [5:0]  dev_addr [4];
    logic [12:0] exp_q [$];
    int          miscompares = 0, n_checks = 0, cyc = 0, bad, k;

    always #25 REF_CLK = ~REF_CLK;

    field_device_frame_master #(.TIMEOUT_CYC(200)) u_field_device_frame_master (
        .REF_CLK, .SRST, .PROTO_EN, .PREAMBLE_LEN, .CMD, .CMD_READY, .RSP,
        .LINK_CHAN, .TX_VALID, .TX_DATA, .TX_READY, .RX_VALID, .RX_DATA,
        .COMM_ERR);
    loop_device_model u_loop_device_model (.clk(REF_CLK), .chan(LINK_CHAN),
        .tx_valid(TX_VALID), .tx_data(TX_DATA), .tx_ready(TX_READY),
        .rx_valid(RX_VALID), .rx_data(RX_DATA), .mode, .pre_len(PREAMBLE_LEN),
        .addr(dev_addr), .bad);

    task automatic check(input logic [12:0] got, input logic [12:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic conclude;
        if (miscompares == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude

    // Each response beat meets the oldest note; a hang is cut off
    always @(posedge REF_CLK) begin
        cyc++;
        if (RSP.valid === 1'b1)
            check({RSP.last, RSP.chk_err, RSP.no_answer, RSP.chan, RSP.data},
                  exp_q.size() != 0 ? exp_q.pop_front() : 13'h1fff);
        if (cyc == 60000) begin
            miscompares++;
            conclude();
        end
    end

    // Check byte is appended here; the master recomputes it anyway
    task automatic send(input logic [1:0] ch, input logic [7:0] f [$]);
        logic [7:0] x;
        x = 8'h00;
        foreach (f[i]) x ^= f[i];
        f.push_back(x);
        foreach (f[i]) begin
            @(negedge REF_CLK);
            CMD = '{1'b1, i == f.size() - 1, ch, f[i]};
            do @(posedge REF_CLK); while (CMD_READY !== 1'b1);
        end
        @(negedge REF_CLK);
        CMD.valid = 1'b0;
    endtask : send

    task automatic client(input logic [1:0] m);
        logic [7:0] f [$];
        logic [7:0] r [$];
        logic [7:0] x;
        logic [1:0] ch;
        ch = 2'($urandom_range(3));
        f = {8'h82, 8'h80 | 8'($urandom_range(63)), 8'($urandom),
             8'($urandom), 8'($urandom), 8'($urandom), 8'h01, 8'h00};
        r = {8'h86, f[1:6], 8'h02, 8'h00, 8'h00};
        x = 8'h00;
        foreach (r[i]) x ^= r[i];
        r.push_back(m == 2'd2 ? ~x : x);
        if (m == 2'd1)
            exp_q.push_back({3'b101, ch, 8'h00});
        else
            foreach (r[i])
                exp_q.push_back({i == r.size() - 1,
                    m == 2'd2 && i == r.size() - 1, 1'b0, ch, r[i]});
        mode = m;
        send(ch, f);
        repeat (30000) if (exp_q.size() != 0) @(negedge REF_CLK);
    endtask : client

    initial begin
        void'($urandom(80));
        CMD = '0;
        PREAMBLE_LEN = 5'(5 + $urandom_range(15));
        repeat (6) @(negedge REF_CLK);
        SRST = 1'b0;
        PROTO_EN = 1'b1;
        // Devices sit off address 0, so every channel scans first
        for (k = 0; k < 3000 && COMM_ERR[0] !== 1'b1; k++) @(negedge REF_CLK);
        check(13'(COMM_ERR[0]), 13'h1);
        for (k = 0; k < 20000 && COMM_ERR !== 4'h0; k++) @(negedge REF_CLK);
        check(13'({COMM_ERR, dev_addr[0] | dev_addr[1] | dev_addr[2]
                   | dev_addr[3]}), 13'h0);
        send(2'd1, {8'h02, 8'h80, 8'h01, 8'h00});
        send(2'd2, {8'h82, 8'hc0, 8'h11, 8'h22, 8'h33, 8'h44, 8'h01, 8'h00});
        check(13'(CMD_READY), 13'h1);
        client(2'd0);
        client(2'd2);
        client(2'd1);
        check(13'(exp_q.size()), 13'h0);
        check(13'(bad), 13'h0);
        conclude();
    end
endmodule : tb_field_device_frame_master
